/* hw/acr_defs.vh */
// Register offsets, field positions and reset values of the calibration configuration bank.
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_ADDR_W 4
`define ACR_OFS_CAL_ADJUST 4'h4
`define ACR_OFS_CAL_VALUES 4'h5
`define ACR_OFS_BIAS_POWER 4'h6
`define ACR_OFS_IL_TIMING 4'h7
`define ACR_OFS_RSVD_A 4'h8
`define ACR_OFS_RSVD_B 4'h9
`define ACR_RST_CAL_ADJUST 16'hDB4B
`define ACR_RST_CAL_VALUES 16'h0000
`define ACR_RST_BIAS_POWER 16'h1C2E
`define ACR_RST_IL_TIMING 16'h8142
`define ACR_RST_RSVD_A 16'h0F0F
`define ACR_RST_RSVD_B 16'h0000
`define ACR_BIT_CAL_SEQ_SEL 14
`define ACR_BIT_SCAN_ACCESS 7
`define ACR_IL_TIMING_MSB 15
`define ACR_IL_TIMING_LSB 9
`endif

/* hw/acr_regs.v */
// Calibration and interleave configuration register bank with scan-access calibration storage.
// What this block does
// - Sequence select high: restore nominals, calibrate termination, then linearity.
// - Sequence select low: keep termination setting, skip it, calibrate linearity only.
// - Scan access bit high opens stored calibration values for read and write.
// - Each self-calibration result lands in the 16-bit calibration values register.
// - Interleave mode shifts sampling rising edge by timing field bits 15 to 9.
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_regs (
    input wire clk_in,
    input wire rst_n_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [`ACR_ADDR_W-1:0] addr_in,
    input wire [15:0] wr_data_in,
    input wire cal_start_in,
    input wire cal_result_valid_in,
    input wire [15:0] cal_result_in,
    input wire interleave_mode_in,
    output reg [15:0] rd_data_out,
    output reg rd_valid_out,
    output wire cal_sequence_select_out,
    output reg cal_restore_nominal_out,
    output reg cal_termination_out,
    output reg cal_linearity_out,
    output wire scan_access_control_out,
    output wire [15:0] cal_values_out,
    output wire [15:0] max_power_adjust_out,
    output wire [6:0] interleave_edge_timing_out,
    output wire interleave_edge_adjust_en_out
);
    // Register storage; each register has its own next-value logic below.
    reg [15:0] cal_adjust_q;
    reg [15:0] cal_adjust_d;
    reg [15:0] cal_values_q;
    reg [15:0] cal_values_d;
    reg [15:0] bias_power_q;
    reg [15:0] bias_power_d;
    reg [15:0] il_timing_q;
    reg [15:0] il_timing_d;
    reg [15:0] rsvd_a_q;
    reg [15:0] rsvd_a_d;
    reg [15:0] rsvd_b_q;
    reg [15:0] rsvd_b_d;
    reg [15:0] rd_data_d;
    reg cal_restore_nominal_d;
    reg cal_termination_d;
    reg cal_linearity_d;
    wire scan_open;
    wire full_sequence;
    wire wr_cal_adjust;
    wire wr_cal_values;
    wire wr_bias_power;
    wire wr_il_timing;
    wire wr_rsvd_a;
    wire wr_rsvd_b;
    wire rd_cal_values;

    // True when an access address selects the given register offset.
    function hit;
        input [`ACR_ADDR_W-1:0] addr;
        input [`ACR_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    assign scan_open = cal_adjust_q[`ACR_BIT_SCAN_ACCESS];
    assign full_sequence = cal_adjust_q[`ACR_BIT_CAL_SEQ_SEL];
    assign scan_access_control_out = scan_open;
    assign cal_sequence_select_out = full_sequence;
    assign cal_values_out = cal_values_q;
    assign max_power_adjust_out = bias_power_q;
    assign interleave_edge_timing_out =
        il_timing_q[`ACR_IL_TIMING_MSB:`ACR_IL_TIMING_LSB];
    assign interleave_edge_adjust_en_out = interleave_mode_in;

    // Write strobes, one per register.
    assign wr_cal_adjust = wr_en_in && hit(addr_in, `ACR_OFS_CAL_ADJUST);
    assign wr_bias_power = wr_en_in && hit(addr_in, `ACR_OFS_BIAS_POWER);
    assign wr_il_timing = wr_en_in && hit(addr_in, `ACR_OFS_IL_TIMING);
    assign wr_rsvd_a = wr_en_in && hit(addr_in, `ACR_OFS_RSVD_A);
    assign wr_rsvd_b = wr_en_in && hit(addr_in, `ACR_OFS_RSVD_B);

    // The stored calibration word is only reachable while the scan gate is open.
    assign wr_cal_values = wr_en_in && scan_open && hit(addr_in, `ACR_OFS_CAL_VALUES);
    assign rd_cal_values = scan_open && hit(addr_in, `ACR_OFS_CAL_VALUES);

    // Reserved bits are stored as written, since the host keeps them intact.
    always @* begin
        cal_adjust_d = cal_adjust_q;
        if (wr_cal_adjust) begin
            cal_adjust_d = wr_data_in;
        end
    end

    always @* begin
        bias_power_d = bias_power_q;
        if (wr_bias_power) begin
            bias_power_d = wr_data_in;
        end
    end

    always @* begin
        il_timing_d = il_timing_q;
        if (wr_il_timing) begin
            il_timing_d = wr_data_in;
        end
    end

    always @* begin
        rsvd_a_d = rsvd_a_q;
        if (wr_rsvd_a) begin
            rsvd_a_d = wr_data_in;
        end
    end

    always @* begin
        rsvd_b_d = rsvd_b_q;
        if (wr_rsvd_b) begin
            rsvd_b_d = wr_data_in;
        end
    end

    // A fresh calibration result beats a host write in the same cycle.
    always @* begin
        cal_values_d = cal_values_q;
        if (cal_result_valid_in) begin
            cal_values_d = cal_result_in;
        end else if (wr_cal_values) begin
            cal_values_d = wr_data_in;
        end
    end

    // Sequence steps are latched at the start pulse so a later rewrite cannot alter a run.
    always @* begin
        cal_restore_nominal_d = cal_restore_nominal_out;
        cal_termination_d = cal_termination_out;
        cal_linearity_d = cal_linearity_out;
        if (cal_start_in) begin
            cal_restore_nominal_d = full_sequence;
            cal_termination_d = full_sequence;
            cal_linearity_d = 1'b1;
        end
    end

    // Read multiplexer; unmapped offsets and a closed scan gate read as zero.
    always @* begin
        rd_data_d = 16'h0000;
        if (hit(addr_in, `ACR_OFS_CAL_ADJUST)) begin
            rd_data_d = cal_adjust_q;
        end else if (rd_cal_values) begin
            rd_data_d = cal_values_q;
        end else if (hit(addr_in, `ACR_OFS_BIAS_POWER)) begin
            rd_data_d = bias_power_q;
        end else if (hit(addr_in, `ACR_OFS_IL_TIMING)) begin
            rd_data_d = il_timing_q;
        end else if (hit(addr_in, `ACR_OFS_RSVD_A)) begin
            rd_data_d = rsvd_a_q;
        end else if (hit(addr_in, `ACR_OFS_RSVD_B)) begin
            rd_data_d = rsvd_b_q;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cal_adjust_q <= `ACR_RST_CAL_ADJUST;
            bias_power_q <= `ACR_RST_BIAS_POWER;
            il_timing_q <= `ACR_RST_IL_TIMING;
            rsvd_a_q <= `ACR_RST_RSVD_A;
            rsvd_b_q <= `ACR_RST_RSVD_B;
        end else begin
            cal_adjust_q <= cal_adjust_d;
            bias_power_q <= bias_power_d;
            il_timing_q <= il_timing_d;
            rsvd_a_q <= rsvd_a_d;
            rsvd_b_q <= rsvd_b_d;
        end
    end

    // Calibration storage is undefined at power-on, so it is left out of reset.
    // A limitation: its reads show unknown data until a result or scan write lands.
    always @(posedge clk_in) begin
        cal_values_q <= cal_values_d;
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cal_restore_nominal_out <= 1'b0;
            cal_termination_out <= 1'b0;
            cal_linearity_out <= 1'b0;
        end else begin
            cal_restore_nominal_out <= cal_restore_nominal_d;
            cal_termination_out <= cal_termination_d;
            cal_linearity_out <= cal_linearity_d;
        end
    end

    // Read data holds between reads so a slow host can pick it up late.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in) begin
                rd_data_out <= rd_data_d;
            end
        end
    end
endmodule // acr_regs

/* testbench/acr_regs_checker.sv */
// Port assertions of the calibration register bank.
`timescale 1ns/1ps
module acr_chk (input wire clk_in, rst_n_in, rd_en_in, rd_valid_out, cal_start_in,
    input wire cal_result_valid_in, cal_sequence_select_out, cal_restore_nominal_out,
    input wire cal_termination_out, cal_linearity_out, scan_access_control_out,
    input wire [3:0] addr_in, input wire [15:0] cal_result_in, rd_data_out, cal_values_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire c = cal_start_in, s = cal_sequence_select_out, k = scan_access_control_out;
    wire r = rd_en_in && addr_in == 4'h5, n = cal_restore_nominal_out, t = cal_termination_out;
    a_seq_nom: assert property (c |=> n == $past(s)) else $error("nom");
    a_seq_term: assert property (c |=> t == $past(s)) else $error("term");
    a_seq_lin: assert property (c |=> cal_linearity_out) else $error("lin");
    a_rd_answer: assert property (rd_en_in |=> rd_valid_out) else $error("ans");
    a_ans_cause: assert property (rd_valid_out |-> $past(rd_en_in)) else $error("src");
    a_scan_shut: assert property (r && !k |=> !rd_data_out) else $error("shut");
    a_scan_open: assert property (r && k |=>
        rd_data_out == $past(cal_values_out)) else $error("open");
    a_cal_store: assert property (cal_result_valid_in |=>
        cal_values_out == $past(cal_result_in)) else $error("store");
endmodule // acr_chk
bind acr_regs acr_chk acr_chk_i (.*);

/* testbench/acr_host.sv */
// Host model; released address and data lines carry inverted values so a stale address never looks held.
`timescale 1ns/1ps
module acr_host (input wire clk_in, input wire [15:0] rd_data_in,
    output reg wr_en_out = 1'b0, rd_en_out = 1'b0, output reg [3:0] addr_out = 4'h0,
    output reg [15:0] wr_data_out = 16'h0000);
    task automatic xfer(input w, input [3:0] a, input [15:0] d, output [15:0] q);
        @(posedge clk_in) {wr_en_out, rd_en_out, addr_out, wr_data_out} <= {w, !w, a, d};
        @(posedge clk_in) {wr_en_out, rd_en_out, addr_out, wr_data_out} <= {2'b00, ~a, ~d};
        @(posedge clk_in) q = rd_data_in;
    endtask
endmodule // acr_host

/* testbench/acr_regs_tb_top.sv */
// Testbench of the calibration register bank.
`timescale 1ns/1ps
module acr_regs_tb_top;
    reg clk_in = 0, rst_n_in = 0, cal_start_in = 0, cal_result_valid_in = 0;
    reg interleave_mode_in = 1;
    reg [15:0] cal_result_in = 16'hA5C3, v;
    wire wr_en_in, rd_en_in, rd_valid_out, cal_sequence_select_out, cal_restore_nominal_out;
    wire cal_termination_out, cal_linearity_out, scan_access_control_out;
    wire interleave_edge_adjust_en_out;
    wire [3:0] addr_in;
    wire [6:0] interleave_edge_timing_out;
    wire [15:0] wr_data_in, rd_data_out, cal_values_out, max_power_adjust_out;
    int n_fail = 0, samples_checked = 0;
    always #50 clk_in = ~clk_in;
    acr_regs acr_regs_i (.*);
    acr_host acr_host_i (.clk_in, .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
        .rd_en_out(rd_en_in), .addr_out(addr_in), .wr_data_out(wr_data_in));
    task t(input w, input [3:0] a, input [15:0] d);
        acr_host_i.xfer(w, a, d, v);
        samples_checked += !w;
        if (!w && v !== d) begin n_fail++; $display("ERROR reg%h exp %h got %h", a, d, v); end
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task cal;
        @(posedge clk_in) cal_start_in <= 1;
        @(posedge clk_in) cal_start_in <= 0;
    endtask
    task summarize;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #100000 n_fail++; summarize; end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1;
        @(negedge clk_in);
        chk("max_power", 16'h1C2E, max_power_adjust_out);
        chk("edge_timing", 16'h0040, {9'h000, interleave_edge_timing_out});
        chk("edge_en", 16'h0001, {15'h0000, interleave_edge_adjust_en_out});
        t(0, 4'h4, 16'hDB4B);
        t(0, 4'h7, 16'h8142);
        t(0, 4'h5, 16'h0000);
        t(0, 4'h8, 16'h0F0F);
        t(0, 4'h9, 16'h0000);
        cal;
        @(negedge clk_in);
        chk("steps_full", 16'h0007, {13'h0000, cal_restore_nominal_out, cal_termination_out,
            cal_linearity_out});
        t(1, 4'h4, 16'h9B4B);
        cal;
        @(negedge clk_in);
        chk("steps_short", 16'h0001, {13'h0000, cal_restore_nominal_out, cal_termination_out,
            cal_linearity_out});
        $display("test sequence done");
        @(posedge clk_in) cal_result_valid_in <= 1;
        @(posedge clk_in) cal_result_valid_in <= 0;
        t(1, 4'h5, 16'h1234);
        t(1, 4'h4, 16'h9BCB);
        t(0, 4'h5, 16'hA5C3);
        t(1, 4'h5, 16'h1234);
        t(0, 4'h5, 16'h1234);
        chk("cal_values", 16'h1234, cal_values_out);
        t(1, 4'h4, 16'hDB4B);
        t(0, 4'h5, 16'h0000);
        t(1, 4'h6, 16'h1C0E);
        t(0, 4'h6, 16'h1C0E);
        chk("max_power", 16'h1C0E, max_power_adjust_out);
        t(1, 4'h7, 16'h0342);
        @(posedge clk_in) interleave_mode_in <= 0;
        @(negedge clk_in);
        chk("edge_timing", 16'h0001, {9'h000, interleave_edge_timing_out});
        chk("edge_en", 16'h0000, {15'h0000, interleave_edge_adjust_en_out});
        $display("test scan done");
        summarize;
    end
endmodule // acr_regs_tb_top
